// file: input_sync.sv
`timescale 1ns/10ps

// Two-flop synchroniser per bit; only the second stage leaves the module.
module input_sync #(
	parameter int                         WIDTH       = 1,
	parameter logic [WIDTH-1:0]           RESET_VALUE = '0
) (
	// Clock and reset.
	input  wire logic                     clock_in,
	input  wire logic                     resetn_in,
	// Asynchronous inputs and their synchronised copies.
	input  wire logic [WIDTH-1:0]         async_in,
	output logic      [WIDTH-1:0]         sync_out
);

	// One identical two-stage chain for each bit.
	genvar bit_index;
	generate
		for (bit_index = 0; bit_index < WIDTH; bit_index++) begin : g_bit
			logic first_q;   // First stage, read only by the second stage.
			logic first_d;   // Next value of the first stage.
			logic second_q;  // Second stage, the usable copy.
			logic second_d;  // Next value of the second stage.

			// The chain simply shifts the pin value along.
			always_comb begin
				first_d  = async_in[bit_index];
				second_d = first_q;
			end

			// Both stages fall to the idle level under reset.
			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					first_q  <= RESET_VALUE[bit_index];
					second_q <= RESET_VALUE[bit_index];
				end else begin
					first_q  <= first_d;
					second_q <= second_d;
				end
			end

			assign sync_out[bit_index] = second_q;
		end
	endgenerate

endmodule

// file: pin_function_mux.sv
`timescale 1ns/10ps

// Chooses what one multiplexed serial memory pin carries.
module pin_function_mux
	import rom_pins_pkg::*;
(
	// Selected function.
	input  wire rom_pins_pkg::pin_mode_type mode_in,
	// Candidate sources.
	input  wire logic                     rom_value_in,
	input  wire logic                     rom_drive_in,
	input  wire logic                     general_out_in,
	input  wire logic                     monitor_enable_in,
	input  wire logic                     monitor_clock_in,
	// Pin value, drive enable and chip select block.
	output logic                          pin_value_out,
	output logic                          pin_drive_out,
	output logic                          block_select_out
);

	// Only memory mode lets the pin be released or the memory be selected.
	always_comb begin
		pin_value_out    = rom_value_in;
		pin_drive_out    = rom_drive_in;
		block_select_out = 1'b1;
		case (mode_in)
			PIN_ROM: begin
				// Memory engine owns the pin.
				pin_value_out    = rom_value_in;
				pin_drive_out    = rom_drive_in;
				block_select_out = 1'b0;
			end
			PIN_GENERAL_OUT: begin
				// Software level, always driven; never an input.
				pin_value_out    = general_out_in;
				pin_drive_out    = 1'b1;
			end
			PIN_MONITOR_ENABLE: begin
				// Mirrors the enable or valid strobe of the internal port.
				pin_value_out    = monitor_enable_in;
				pin_drive_out    = 1'b1;
			end
			PIN_MONITOR_CLOCK: begin
				// Mirrors the sampled clock of the internal port.
				pin_value_out    = monitor_clock_in;
				pin_drive_out    = 1'b1;
			end
			default: begin
				// Unknown selection keeps the memory deselected and the pin driven.
				pin_value_out    = 1'b0;
				pin_drive_out    = 1'b1;
			end
		endcase
	end

endmodule

// file: rom_model.sv
`timescale 1ns/10ps

// Serial memory on the shared data line.
module rom_model (
	// Clock used only to age a released line.
	input  wire logic	clock_in,
	// Device side of the line and the memory's reply.
	input  wire logic	select_in,
	input  wire logic	dev_data_in,
	input  wire logic	dev_oe_in,
	input  wire logic	reply_bit_in,
	input  wire logic	reply_en_in,
	// Resolved line level seen by both ends.
	output logic		line_out
);
	logic	float_q = 1'b0;	// Changing level of an undriven line.

	// Device drive wins; memory answers when selected.
	always_comb begin
		if (dev_oe_in) begin
			line_out = dev_data_in;
		end else if (select_in && reply_en_in) begin
			line_out = reply_bit_in;
		end else begin
			line_out = float_q;
		end
	end

	// Toggles every cycle so a stale sample cannot pass by luck.
	always_ff @(posedge clock_in) begin
		float_q <= !float_q;
	end
endmodule

// file: rom_pins_asserts.sv
`timescale 1ns/10ps

// Checks the top ports.
module rom_pins_asserts
	import rom_pins_pkg::*;
(
	// Clock, resets and host strobes.
	input wire logic						clock_in,
	input wire logic						resetn_in,
	input wire logic						hard_reset_n_in,
	input wire logic						host_select_n_in,
	input wire logic						host_write_strobe_n_in,
	input wire logic						host_read_strobe_n_in,
	// Pin configuration and power controls.
	input wire logic						config_load_in,
	input wire rom_pins_pkg::pin_mode_type	data_pin_mode_in,
	input wire rom_pins_pkg::pin_mode_type	clock_pin_mode_in,
	input wire logic						general_out_three_in,
	input wire logic						general_out_four_in,
	input wire logic						wake_enable_in,
	input wire logic						wake_event_in,
	input wire logic						wake_clear_in,
	input wire logic						wake_polarity_in,
	input wire logic						wake_open_drain_in,
	// Outputs under watch.
	input wire logic						rom_chip_select_out,
	input wire logic						rom_serial_clock_pin_out,
	input wire logic						rom_serial_data_pin_out,
	input wire logic						rom_serial_data_pin_oe_out,
	input wire logic						wake_indicator_out,
	input wire logic						wake_indicator_oe_out,
	input wire logic						device_in_reset_out,
	input wire logic						power_save_out,
	input wire logic						write_unlocked_out,
	input wire logic						host_write_accept_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	// Qualified host write.
	sequence host_wr_s;
		!host_select_n_in && !host_write_strobe_n_in;
	endsequence

	// Outputs while held in reset.
	sequence reset_state_s;
		device_in_reset_out && !rom_chip_select_out && rom_serial_clock_pin_out &&
		!rom_serial_data_pin_oe_out && !power_save_out && !write_unlocked_out;
	endsequence

	cs_forced_off_a: assert property (
		config_load_in && (data_pin_mode_in != PIN_ROM || clock_pin_mode_in != PIN_ROM)
		|-> ##2 !rom_chip_select_out[*3]) else $error("select in alternate mode");
	data_gpo_a: assert property (
		config_load_in && data_pin_mode_in == PIN_GENERAL_OUT ##1 !config_load_in[*2] |->
		rom_serial_data_pin_oe_out && rom_serial_data_pin_out == $past(general_out_three_in))
		else $error("data pin not showing general output");
	clock_gpo_a: assert property (
		config_load_in && clock_pin_mode_in == PIN_GENERAL_OUT ##1 !config_load_in[*2] |->
		rom_serial_clock_pin_out == $past(general_out_four_in))
		else $error("clock pin not showing general output");
	save_hold_a: assert property (
		host_select_n_in[*4] ##0 power_save_out |=> power_save_out)
		else $error("left power saving");
	wake_exit_a: assert property (
		power_save_out ##0 host_wr_s |-> ##[1:5] !power_save_out)
		else $error("write did not wake");
	accept_lock_a: assert property (
		host_write_accept_out |-> $past(write_unlocked_out) ##1 !host_write_accept_out)
		else $error("bad write accept");
	unlock_read_a: assert property (
		$rose(write_unlocked_out) |-> !$past(host_select_n_in, 2) &&
		!$past(host_read_strobe_n_in, 2)) else $error("unlock without a host read");
	wake_push_a: assert property (
		wake_event_in && wake_enable_in && !wake_open_drain_in ##1 !wake_clear_in |->
		##1 wake_indicator_oe_out && wake_indicator_out == wake_polarity_in)
		else $error("push-pull wake level wrong");
	wake_od_a: assert property (
		wake_event_in && wake_enable_in && wake_open_drain_in ##1 !wake_clear_in |->
		##1 !wake_indicator_out && wake_indicator_oe_out == !wake_polarity_in)
		else $error("open-drain wake level wrong");
	hard_reset_a: assert property (
		!hard_reset_n_in[*5] |-> reset_state_s) else $error("hard reset state");
endmodule

bind serial_rom_pins_reset_wake rom_pins_asserts chk (.*);

// file: rom_pins_pkg.sv
package rom_pins_pkg;

	// Function selected for one multiplexed serial memory pin.
	typedef enum logic [1:0] {
		PIN_ROM,
		PIN_GENERAL_OUT,
		PIN_MONITOR_ENABLE,
		PIN_MONITOR_CLOCK
	} pin_mode_type;

	// Both pins reset to serial memory use.
	localparam pin_mode_type PIN_MODE_RESET      = PIN_ROM;

	// Reference crystal rate and the rate of the logic clock.
	localparam int           CRYSTAL_FREQ_MHZ    = 25;
	localparam int           CLOCK_FREQ_MHZ      = 200;

	// Depth of every input synchroniser.
	localparam int           SYNC_STAGES         = 2;

	// Bit positions of the synchronised input vector.
	localparam int           SYNC_HARD_RESET     = 0;
	localparam int           SYNC_HOST_SELECT    = 1;
	localparam int           SYNC_HOST_WRITE     = 2;
	localparam int           SYNC_HOST_READ      = 3;
	localparam int           SYNC_TX_ENABLE      = 4;
	localparam int           SYNC_TX_CLOCK       = 5;
	localparam int           SYNC_RX_VALID       = 6;
	localparam int           SYNC_RX_CLOCK       = 7;
	localparam int           SYNC_ROM_DATA       = 8;
	localparam int           SYNC_WIDTH          = 9;

	// Idle level of synchronised inputs.
	localparam logic [8:0]   SYNC_RESET_VALUE    = 9'h00f;

	// Reset values of control and status state.
	localparam logic         POWER_SAVE_RESET    = 1'b0;
	localparam logic         WRITE_UNLOCK_RESET  = 1'b0;
	localparam logic         WAKE_PENDING_RESET  = 1'b0;
	localparam logic         CHIP_SELECT_IDLE    = 1'b0;
	localparam logic         PIN_OUT_RESET       = 1'b0;
	localparam logic         ROM_CLOCK_RESET     = 1'b1;

endpackage

// file: serial_rom_pins_reset_wake.sv
`timescale 1ns/10ps

// What this block does
// - Memory mode: data pin drives and samples.
// - Data pin: general output or transmit monitor.
// - Data pin alternate modes force chip select off.
// - No general input on data, clock pins.
// - Clock pin: memory clock, output, receive monitor.
// - Clock pin alternate modes force chip select off.
// - Reference clock from 25 MHz crystal.
// - Hardware reset clears all logic and registers; the input synchroniser flops clear only on resetn_in.
// - Writes ignored until first read after reset.
// - Enabled wake event asserts wake indicator.
// - Wake polarity and drive type programmable.
// - Wake indicator alone does not wake device.
// - Only host write cycle ends power saving.
module serial_rom_pins_reset_wake
	import rom_pins_pkg::*;
(
	// Clock and reset.
	input  wire logic                     clock_in,
	input  wire logic                     resetn_in,
	// External reset pin and soft reset request.
	input  wire logic                     hard_reset_n_in,
	input  wire logic                     soft_reset_bit_in,
	// Host bus strobes, all active low.
	input  wire logic                     host_select_n_in,
	input  wire logic                     host_write_strobe_n_in,
	input  wire logic                     host_read_strobe_n_in,
	// Pin function configuration, taken on the load strobe; general output levels used directly.
	input  wire logic                     config_load_in,
	input  wire rom_pins_pkg::pin_mode_type data_pin_mode_in,
	input  wire rom_pins_pkg::pin_mode_type clock_pin_mode_in,
	input  wire logic                     general_out_three_in,
	input  wire logic                     general_out_four_in,
	// Internal transceiver port signals to monitor.
	input  wire logic                     mii_tx_enable_in,
	input  wire logic                     mii_tx_clock_in,
	input  wire logic                     mii_rx_valid_in,
	input  wire logic                     mii_rx_clock_in,
	// Serial memory engine requests.
	input  wire logic                     rom_select_req_in,
	input  wire logic                     rom_clock_req_in,
	input  wire logic                     rom_data_req_in,
	input  wire logic                     rom_data_drive_req_in,
	// Power management controls.
	input  wire logic                     enter_power_save_in,
	input  wire logic                     wake_enable_in,
	input  wire logic                     wake_event_in,
	input  wire logic                     wake_clear_in,
	input  wire logic                     wake_polarity_in,
	input  wire logic                     wake_open_drain_in,
	// Serial memory pins.
	output logic                          rom_chip_select_out,
	output logic                          rom_serial_clock_pin_out,
	output logic                          rom_serial_data_pin_out,
	output logic                          rom_serial_data_pin_oe_out,
	input  wire logic                     rom_serial_data_pin_in,
	output logic                          rom_data_sampled_out,
	// Wake indicator pin.
	output logic                          wake_indicator_out,
	output logic                          wake_indicator_oe_out,
	// Status toward the rest of the device.
	output logic                          device_in_reset_out,
	output logic                          power_save_out,
	output logic                          write_unlocked_out,
	output logic                          host_write_accept_out
);

	import rom_pins_pkg::*;

	// Synchronised copies of every input from outside this clock.
	logic [SYNC_WIDTH-1:0] async_bits;     // Raw inputs in vector order.
	logic [SYNC_WIDTH-1:0] sync_bits;      // Their synchronised copies.

	// Pin function configuration state.
	pin_mode_type          data_mode_q;    // Current data pin function.
	pin_mode_type          data_mode_d;    // Next data pin function.
	pin_mode_type          clock_mode_q;   // Current clock pin function.
	pin_mode_type          clock_mode_d;   // Next clock pin function.

	// Host cycle edge detection and access state.
	logic                  write_cycle_q;  // Write cycle seen last cycle.
	logic                  write_cycle_d;  // Write cycle seen now.
	logic                  read_cycle_q;   // Read cycle seen last cycle.
	logic                  read_cycle_d;   // Read cycle seen now.
	logic                  write_start;    // First cycle of a host write.
	logic                  read_start;     // First cycle of a host read.
	logic                  power_save_q;   // Device sits in a power-saving mode.
	logic                  power_save_d;   // Next power-saving state.
	logic                  unlocked_q;     // A read has happened since reset or wake.
	logic                  unlocked_d;     // Next unlock state.
	logic                  accept_q;       // Registered accepted write pulse.
	logic                  accept_d;       // Next accepted write pulse.
	logic                  wake_pending_q; // Wake event waiting for the system.
	logic                  wake_pending_d; // Next wake pending state.

	// Combined internal reset.
	logic                  logic_reset;    // High while any reset source acts.

	// Pin multiplexer results.
	logic                  data_value;     // Value for the data pin.
	logic                  data_drive;     // Drive enable for the data pin.
	logic                  data_block;     // Data pin function forbids selection.
	logic                  clock_value;    // Value for the clock pin.
	logic                  clock_block;    // Clock pin function forbids selection.

	// Registered pin outputs.
	logic                  select_q;       // Chip select flop.
	logic                  select_d;       // Next chip select.
	logic                  sclk_q;         // Clock pin flop.
	logic                  sclk_d;         // Next clock pin value.
	logic                  dout_q;         // Data pin value flop.
	logic                  dout_d;         // Next data pin value.
	logic                  doe_q;          // Data pin drive flop.
	logic                  doe_d;          // Next data pin drive.
	logic                  sampled_q;      // Sampled memory data flop.
	logic                  sampled_d;      // Next sampled memory data.
	logic                  wake_pin_q;     // Wake pin value flop.
	logic                  wake_pin_d;     // Next wake pin value.
	logic                  wake_oe_q;      // Wake pin drive flop.
	logic                  wake_oe_d;      // Next wake pin drive.
	logic                  wake_level;     // Electrical level of the wake indicator.
	logic                  in_reset_q;     // Reset status flop.

	// Gather every asynchronous input, including the monitored link clocks.
	always_comb begin
		async_bits                   = '0;
		async_bits[SYNC_HARD_RESET]  = hard_reset_n_in;
		async_bits[SYNC_HOST_SELECT] = host_select_n_in;
		async_bits[SYNC_HOST_WRITE]  = host_write_strobe_n_in;
		async_bits[SYNC_HOST_READ]   = host_read_strobe_n_in;
		async_bits[SYNC_TX_ENABLE]   = mii_tx_enable_in;
		async_bits[SYNC_TX_CLOCK]    = mii_tx_clock_in;
		async_bits[SYNC_RX_VALID]    = mii_rx_valid_in;
		async_bits[SYNC_RX_CLOCK]    = mii_rx_clock_in;
		async_bits[SYNC_ROM_DATA]    = rom_serial_data_pin_in;
	end

	// Two flops on every pin before any logic reads it.
	input_sync #(
		.WIDTH       (SYNC_WIDTH),
		.RESET_VALUE (SYNC_RESET_VALUE)
	) u_input_sync (
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.async_in  (async_bits),
		.sync_out  (sync_bits)
	);

	// The logic clock is derived from the 25 MHz crystal reference; the
	// reset pin and soft reset clear all state except the input synchroniser, which only resetn_in clears.
	always_comb begin
		logic_reset = !resetn_in || !sync_bits[SYNC_HARD_RESET] || soft_reset_bit_in;
	end

	// Pin functions reload only on the load strobe and reset to memory mode.
	always_comb begin
		data_mode_d  = data_mode_q;
		clock_mode_d = clock_mode_q;
		if (config_load_in) begin
			data_mode_d  = data_pin_mode_in;
			clock_mode_d = clock_pin_mode_in;
		end
	end

	// Configuration registers.
	always_ff @(posedge clock_in) begin
		if (logic_reset) begin
			data_mode_q  <= PIN_MODE_RESET;
			clock_mode_q <= PIN_MODE_RESET;
		end else begin
			data_mode_q  <= data_mode_d;
			clock_mode_q <= clock_mode_d;
		end
	end

	// Data pin: memory data, general output three or transmit monitor.
	pin_function_mux u_data_mux (
		.mode_in           (data_mode_q),
		.rom_value_in      (rom_data_req_in),
		.rom_drive_in      (rom_data_drive_req_in),
		.general_out_in    (general_out_three_in),
		.monitor_enable_in (sync_bits[SYNC_TX_ENABLE]),
		.monitor_clock_in  (sync_bits[SYNC_TX_CLOCK]),
		.pin_value_out     (data_value),
		.pin_drive_out     (data_drive),
		.block_select_out  (data_block)
	);

	// Clock pin: memory clock, general output four or receive monitor.
	pin_function_mux u_clock_mux (
		.mode_in           (clock_mode_q),
		.rom_value_in      (rom_clock_req_in),
		.rom_drive_in      (1'b1),
		.general_out_in    (general_out_four_in),
		.monitor_enable_in (sync_bits[SYNC_RX_VALID]),
		.monitor_clock_in  (sync_bits[SYNC_RX_CLOCK]),
		.pin_value_out     (clock_value),
		.pin_drive_out     (),
		.block_select_out  (clock_block)
	);

	// Host cycle detection: a write is select and write strobe both low.
	always_comb begin
		write_cycle_d = !sync_bits[SYNC_HOST_SELECT] && !sync_bits[SYNC_HOST_WRITE];
		read_cycle_d  = !sync_bits[SYNC_HOST_SELECT] && !sync_bits[SYNC_HOST_READ];
		write_start   = write_cycle_d && !write_cycle_q;
		read_start    = read_cycle_d && !read_cycle_q;
	end

	// Power state, write unlock and wake indicator next values.
	always_comb begin
		power_save_d   = power_save_q;
		unlocked_d     = unlocked_q;
		accept_d       = 1'b0;
		wake_pending_d = wake_pending_q;
		if (write_start && power_save_q) begin
			// Any write data wakes the device, but the write itself is not
			// carried out and a fresh read is needed before writing.
			power_save_d = 1'b0;
			unlocked_d   = 1'b0;
		end else begin
			if (enter_power_save_in) begin
				power_save_d = 1'b1;
			end
			if (read_start) begin
				unlocked_d = 1'b1;
			end
			if (write_start && unlocked_q) begin
				accept_d = 1'b1;
			end
		end
		// A wake event only raises the indicator; power state is untouched.
		if (wake_clear_in) begin
			wake_pending_d = 1'b0;
		end
		if (wake_event_in && wake_enable_in) begin
			wake_pending_d = 1'b1;
		end
	end

	// Power and access state registers.
	always_ff @(posedge clock_in) begin
		if (logic_reset) begin
			write_cycle_q  <= 1'b0;
			read_cycle_q   <= 1'b0;
			power_save_q   <= POWER_SAVE_RESET;
			unlocked_q     <= WRITE_UNLOCK_RESET;
			accept_q       <= 1'b0;
			wake_pending_q <= WAKE_PENDING_RESET;
		end else begin
			write_cycle_q  <= write_cycle_d;
			read_cycle_q   <= read_cycle_d;
			power_save_q   <= power_save_d;
			unlocked_q     <= unlocked_d;
			accept_q       <= accept_d;
			wake_pending_q <= wake_pending_d;
		end
	end

	// Pin output next values.
	always_comb begin
		// Either pin in an alternate role keeps the memory deselected.
		select_d   = (data_block || clock_block) ? CHIP_SELECT_IDLE : rom_select_req_in;
		sclk_d     = clock_value;
		dout_d     = data_value;
		doe_d      = data_drive;
		// Memory data is sampled from the pin only in memory mode.
		sampled_d  = (data_mode_q == PIN_ROM) ? sync_bits[SYNC_ROM_DATA] : sampled_q;
		// Active level follows the programmed polarity.
		wake_level = wake_pending_q ? wake_polarity_in : !wake_polarity_in;
		if (wake_open_drain_in) begin
			// Open drain only pulls low and floats for a high level.
			wake_pin_d = 1'b0;
			wake_oe_d  = !wake_level;
		end else begin
			wake_pin_d = wake_level;
			wake_oe_d  = 1'b1;
		end
	end

	// Pin output registers; every pin output and the reset status come from one of these.
	always_ff @(posedge clock_in) begin
		if (logic_reset) begin
			select_q   <= CHIP_SELECT_IDLE;
			sclk_q     <= ROM_CLOCK_RESET;
			dout_q     <= PIN_OUT_RESET;
			doe_q      <= 1'b0;
			sampled_q  <= PIN_OUT_RESET;
			wake_pin_q <= PIN_OUT_RESET;
			wake_oe_q  <= 1'b0;
			in_reset_q <= 1'b1;
		end else begin
			select_q   <= select_d;
			sclk_q     <= sclk_d;
			dout_q     <= dout_d;
			doe_q      <= doe_d;
			sampled_q  <= sampled_d;
			wake_pin_q <= wake_pin_d;
			wake_oe_q  <= wake_oe_d;
			in_reset_q <= 1'b0;
		end
	end

	// Drive the ports from their flops.
	assign rom_chip_select_out        = select_q;
	assign rom_serial_clock_pin_out   = sclk_q;
	assign rom_serial_data_pin_out    = dout_q;
	assign rom_serial_data_pin_oe_out = doe_q;
	assign rom_data_sampled_out       = sampled_q;
	assign wake_indicator_out         = wake_pin_q;
	assign wake_indicator_oe_out      = wake_oe_q;
	assign device_in_reset_out        = in_reset_q;
	assign power_save_out             = power_save_q;
	assign write_unlocked_out         = unlocked_q;
	assign host_write_accept_out      = accept_q;

endmodule

// file: tb_serial_rom_pins_reset_wake.sv
`timescale 1ns/10ps

// Bench for pins, host unlock and wake.
module tb_serial_rom_pins_reset_wake;
	import rom_pins_pkg::*;

	// Design inputs.
	logic			clock_in, resetn_in, hard_reset_n_in, soft_reset_bit_in, config_load_in;
	logic			host_select_n_in, host_write_strobe_n_in, host_read_strobe_n_in;
	pin_mode_type	data_pin_mode_in, clock_pin_mode_in;
	logic			general_out_three_in, general_out_four_in, mii_tx_enable_in;
	logic			mii_tx_clock_in, mii_rx_valid_in, mii_rx_clock_in, rom_select_req_in;
	logic			rom_clock_req_in, rom_data_req_in, rom_data_drive_req_in;
	logic			enter_power_save_in, wake_enable_in, wake_event_in, wake_clear_in;
	logic			wake_polarity_in, wake_open_drain_in;
	// Design outputs and memory line.
	logic			rom_chip_select_out, rom_serial_clock_pin_out, rom_serial_data_pin_out;
	logic			rom_serial_data_pin_oe_out, rom_data_sampled_out, wake_indicator_out;
	logic			wake_indicator_oe_out, device_in_reset_out, power_save_out;
	logic			write_unlocked_out, host_write_accept_out, data_line;
	// Memory reply, accept capture, counters.
	logic			reply_bit, reply_en, seen;
	int				err_total, tests_run, cycles, ones;

	serial_rom_pins_reset_wake uut (.*, .rom_serial_data_pin_in(data_line));

	rom_model mem (
		.clock_in(clock_in), .select_in(rom_chip_select_out),
		.dev_data_in(rom_serial_data_pin_out), .dev_oe_in(rom_serial_data_pin_oe_out),
		.reply_bit_in(reply_bit), .reply_en_in(reply_en), .line_out(data_line));

	// Logic clock at 200 MHz.
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = !clock_in;
	end

	// Transceiver clocks, 48 ns, free phase.
	initial begin
		mii_tx_clock_in = 1'b0;
		#3.3;
		forever #24 mii_tx_clock_in = !mii_tx_clock_in;
	end
	initial begin
		mii_rx_clock_in = 1'b0;
		#11.1;
		forever #24 mii_rx_clock_in = !mii_rx_clock_in;
	end

	// Ends a hung run.
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_total = err_total + 1;
			finish_test();
		end
	end

	// Compares a bit with its expected value.
	task automatic chk(input logic got, input logic exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits n falling edges.
	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	// One-cycle pulse, then settle.
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(3);
	endtask

	// One host access held seven cycles; strobes then idle long enough to re-arm.
	task automatic host_cycle(input logic wr);
		seen = 1'b0;
		{host_select_n_in, host_write_strobe_n_in, host_read_strobe_n_in} = {1'b0, !wr, wr};
		repeat (7) begin
			tick(1);
			seen = seen | host_write_accept_out;
		end
		{host_select_n_in, host_write_strobe_n_in, host_read_strobe_n_in} = 3'h7;
		tick(3);
	endtask

	// Checks the wake pin for a pending state.
	task automatic wake_chk(input logic pend);
		logic lvl;
		lvl = pend ? wake_polarity_in : !wake_polarity_in;
		chk(wake_indicator_out, wake_open_drain_in ? 1'b0 : lvl);
		chk(wake_indicator_oe_out, wake_open_drain_in ? !lvl : 1'b1);
	endtask

	// Prints counts and verdict, then ends.
	task automatic finish_test();
		$display("checks=%0d errors=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		{resetn_in, soft_reset_bit_in, config_load_in, general_out_three_in} = '0;
		{general_out_four_in, rom_clock_req_in} = '0;
		{rom_data_req_in, rom_data_drive_req_in, enter_power_save_in, wake_enable_in} = '0;
		{wake_event_in, wake_clear_in, wake_polarity_in, wake_open_drain_in} = '0;
		{hard_reset_n_in, host_select_n_in, host_write_strobe_n_in} = '1;
		{host_read_strobe_n_in, rom_select_req_in, mii_tx_enable_in, mii_rx_valid_in} = '1;
		{reply_bit, reply_en, seen} = '0;
		data_pin_mode_in = PIN_ROM;
		clock_pin_mode_in = PIN_ROM;
		{err_total, tests_run, cycles, ones} = '0;
		tick(4);
		chk(device_in_reset_out, 1'b1);
		chk(rom_serial_clock_pin_out, 1'b1);
		resetn_in = 1'b1;
		tick(3);
		chk(rom_chip_select_out, 1'b1);
		chk(rom_serial_clock_pin_out, 1'b0);
		// Memory mode: sample, then drive.
		reply_en = 1'b1;
		for (int b = 0; b < 2; b++) begin
			reply_bit = b[0];
			tick(4);
			chk(rom_data_sampled_out, b[0]);
		end
		rom_data_drive_req_in = 1'b1;
		for (int b = 0; b < 2; b++) begin
			rom_data_req_in = b[0];
			tick(2);
			chk(rom_serial_data_pin_oe_out, 1'b1);
			chk(data_line, b[0]);
		end
		// Each alternate function on each pin.
		for (int m = 1; m < 4; m++) begin
			for (int p = 0; p < 2; p++) begin
				data_pin_mode_in = p ? PIN_ROM : pin_mode_type'(m);
				clock_pin_mode_in = p ? pin_mode_type'(m) : PIN_ROM;
				pulse(config_load_in);
				chk(rom_chip_select_out, 1'b0);
				chk(rom_serial_data_pin_oe_out, 1'b1);
				ones = 0;
				repeat (12) begin
					tick(1);
					ones += p ? rom_serial_clock_pin_out : rom_serial_data_pin_out;
				end
				chk(m == 1 ? ones == 0 : m == 2 ? ones == 12 : ones > 0 && ones < 12, 1'b1);
			end
		end
		data_pin_mode_in = PIN_ROM;
		clock_pin_mode_in = PIN_ROM;
		pulse(config_load_in);
		chk(rom_chip_select_out, 1'b1);
		// Writes refused until the first read.
		host_cycle(1'b1);
		chk(seen, 1'b0);
		host_cycle(1'b0);
		chk(write_unlocked_out, 1'b1);
		for (int w = 0; w < 2; w++) begin
			host_cycle(1'b1);
			chk(seen, 1'b1);
		end
		// Wake events in power saving.
		pulse(enter_power_save_in);
		chk(power_save_out, 1'b1);
		for (int k = 0; k < 4; k++) begin
			{wake_polarity_in, wake_open_drain_in} = k[1:0];
			wake_enable_in = 1'b0;
			pulse(wake_event_in);
			wake_chk(1'b0);
			wake_enable_in = 1'b1;
			pulse(wake_event_in);
			wake_chk(1'b1);
			chk(power_save_out, 1'b1);
			pulse(wake_clear_in);
			wake_chk(1'b0);
		end
		host_cycle(1'b0);
		chk(power_save_out, 1'b1);
		host_cycle(1'b1);
		chk(seen, 1'b0);
		chk(power_save_out, 1'b0);
		chk(write_unlocked_out, 1'b0);
		host_cycle(1'b0);
		host_cycle(1'b1);
		chk(seen, 1'b1);
		// Hard and soft reset.
		clock_pin_mode_in = PIN_GENERAL_OUT;
		pulse(config_load_in);
		hard_reset_n_in = 1'b0;
		tick(6);
		chk(device_in_reset_out, 1'b1);
		chk(write_unlocked_out, 1'b0);
		hard_reset_n_in = 1'b1;
		tick(5);
		chk(device_in_reset_out, 1'b0);
		chk(rom_chip_select_out, 1'b1);
		soft_reset_bit_in = 1'b1;
		tick(2);
		chk(device_in_reset_out, 1'b1);
		soft_reset_bit_in = 1'b0;
		tick(2);
		chk(device_in_reset_out, 1'b0);
		finish_test();
	end
endmodule
